// ==== rtl/mpo_pkg.sv ====
// constants for the monitor pulse output block
// assumes a 100 MHz control clock and monitor data in 0.01 % units
package mpo_pkg;
  // ****************
  // register offsets
  // ****************
  localparam logic [3:0] ADDR_WAVE = 4'h0;
  localparam logic [3:0] ADDR_FSF = 4'h1;
  localparam logic [3:0] ADDR_SRC = 4'h2;
  localparam logic [3:0] ADDR_BASIS = 4'h3;
  localparam logic [3:0] ADDR_TMODE = 4'h4;
  localparam logic [3:0] ADDR_FTIME = 4'h5;
  localparam logic [3:0] ADDR_SIGN = 4'h6;
  localparam logic [3:0] ADDR_BIAS = 4'h7;
  localparam logic [3:0] ADDR_GAIN = 4'h8;
  localparam logic [3:0] ADDR_TLVL = 4'h9;
  localparam logic [3:0] ADDR_COEF = 4'hA;
  localparam logic [3:0] ADDR_OTYPE = 4'hB;
  localparam logic [3:0] ADDR_DUTY = 4'hC;
  localparam logic [3:0] ADDR_FREQ = 4'hD;
  // ****************
  // codes
  // ****************
  localparam logic [1:0] WAVE_PWM = 2'h0;
  localparam logic [1:0] WAVE_FREQ = 2'h1;
  localparam logic [1:0] SRC_OUT_FREQ = 2'h0;
  localparam logic [1:0] SRC_PULSE_IN = 2'h1;
  localparam logic [1:0] SRC_AUX_A = 2'h2;
  localparam logic [1:0] BASIS_BIAS = 2'h0;
  localparam logic [1:0] BASIS_FULL = 2'h1;
  localparam logic [1:0] TMODE_OFF = 2'h0;
  localparam logic [1:0] TMODE_ON = 2'h1;
  localparam logic [1:0] SIGN_ABS = 2'h0;
  localparam logic [1:0] SIGN_KEEP = 2'h1;
  localparam logic [1:0] OTYPE_VOLT = 2'h1;
  localparam logic [1:0] OTYPE_PULSE = 2'h3;
  // ****************
  // ranges and reset values
  // ****************
  localparam int FS = 10000;
  localparam logic [15:0] FSF_MAX = 16'h7D00;
  localparam logic [15:0] FSF_RST = 16'h05A0;
  localparam int FTIME_MIN = 1;
  localparam int FTIME_MAX = 500;
  localparam logic [15:0] FTIME_RST = 16'h000A;
  localparam int PCT_MAX = 1000;
  localparam int GAIN_MAX = 10000;
  localparam logic [15:0] GAIN_RST = 16'h03E8;
  localparam logic [15:0] TLVL_RST = 16'h03E8;
  localparam logic [15:0] BIAS_RST = 16'h0000;
  localparam int COEF_MIN = 1;
  localparam int COEF_MAX = 10000;
  localparam logic [15:0] COEF_RST = 16'h0064;
  localparam int FILT_FRAC = 8;
  // ****************
  // timing
  // ****************
  localparam longint CLK_HZ = 100000000;
  localparam int CLK_NS = 10;
  localparam real PWM_PERIOD_MS = 6.4;
  localparam int PWM_CYC = int'(PWM_PERIOD_MS * 1.0e6 / CLK_NS);
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;
endpackage

// ==== rtl/mpo_core.sv ====
// monitor value to pulse train on the multipurpose output pin
// assumes monitor inputs and the register port share clk
// Notes on behaviour
// - the pin carries pulses only while the output type holds code 03.
// - code 00 gives 6.4 ms PWM, code 01 a square wave; 01 after reset.
// - in frequency mode full scale gives the set frequency, 0..32000 Hz.
// - the generated frequency is capped at 32 kHz whatever the data.
// - the source select picks the monitor; output frequency by default.
// - test mode code 01 outputs the test level; 00 restores the monitor.
// - the test level is -100.0..100.0 % of full scale, default 100.0 %.
// - the value is low-pass filtered, 1..500 ms, default 10 ms.
// - negative data becomes absolute for code 00, stays signed for 01.
// - a bias of -100.0..100.0 % shifts the zero point, default 0.0 %.
// - a gain of -1000.0..1000.0 % sets the slope, default 100.0 %.
// - gain and bias act the same for PWM and frequency output.
// - basis 00 adds bias after gain so the slope ignores bias.
// - basis 01 makes bias the zero point with full scale kept at 100 %.
// - the pulse input monitor is scaled by 0.01..100.00, default 1.0.
// - output type 01, the default, leaves the pin to the analog stage.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
module mpo_core
  import mpo_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC,
  parameter int PWM_CYCLES = PWM_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic signed [15:0] output_frequency_monitor,
  input wire logic signed [15:0] pulse_input_monitor,
  input wire logic signed [15:0] aux_monitor_a,
  input wire logic signed [15:0] aux_monitor_b,
  output logic multipurpose_output_pin,
  output logic multipurpose_output_pin_oe
);
  // ****************
  // state
  // ****************
  typedef struct packed {
    logic [1:0] waveform_select;
    logic [15:0] full_scale_frequency;
    logic [1:0] monitor_source_select;
    logic [1:0] gain_basis_select;
    logic [1:0] test_mode_enable;
    logic [15:0] output_filter_time;
    logic [1:0] sign_handling_select;
    logic signed [15:0] bias_setting;
    logic signed [15:0] gain_setting;
    logic signed [15:0] test_level;
    logic [15:0] pulse_input_scale_coeff;
    logic [1:0] terminal_output_type;
    logic [15:0] rdata;
    logic [19:0] ms_cnt;
    logic signed [31:0] filt;
    logic [19:0] pwm_cnt;
    logic [31:0] phase;
    logic [15:0] duty;
    logic [15:0] freq;
    logic pin;
    logic oe;
  } mpo_state_t;

  mpo_state_t q;
  mpo_state_t d;

  localparam logic signed [47:0] LIM = 48'sh0000_0000_4E20;
  localparam logic [19:0] MS_LAST = 20'(MS_CYCLES - 1);
  localparam logic [19:0] PWM_LAST = 20'(PWM_CYCLES - 1);

  // saturate a wide signed value into a window
  function automatic logic signed [47:0] sat(
    input logic signed [47:0] v,
    input logic signed [47:0] lo,
    input logic signed [47:0] hi
  );
    if (v < lo) begin
      sat = lo;
    end else if (v > hi) begin
      sat = hi;
    end else begin
      sat = v;
    end
  endfunction

  // register write data clamped to a setting range
  function automatic logic [15:0] wsat(
    input logic [15:0] w,
    input int lo,
    input int hi
  );
    logic signed [47:0] s;
    s = 48'(signed'(w));
    wsat = 16'(sat(s, 48'(lo), 48'(hi)));
  endfunction

  // unsigned settings: 16'hFFFF is far above range, not minus one
  function automatic logic [15:0] wusat(
    input logic [15:0] w,
    input int lo,
    input int hi
  );
    logic signed [47:0] s;
    s = signed'(48'(w));
    wusat = 16'(sat(s, 48'(lo), 48'(hi)));
  endfunction

  logic signed [47:0] src_v;
  logic signed [47:0] sel_v;
  logic signed [47:0] gained;
  logic signed [47:0] target;
  logic signed [47:0] err;
  logic signed [47:0] duty_w;
  logic [47:0] freq_w;
  logic [63:0] inc;
  logic ms_tick;
  logic pwm_hi;

  // ****************
  // next state
  // ****************
  always_comb begin
    d = q;
    ms_tick = (q.ms_cnt >= MS_LAST);
    // monitor source choice
    case (q.monitor_source_select)
      SRC_OUT_FREQ: begin
        src_v = 48'(output_frequency_monitor);
      end
      SRC_PULSE_IN: begin
        // coefficient in 0.01 steps
        // signed product, or negative pulse input wraps
        src_v = 48'(pulse_input_monitor) *
          signed'(48'(q.pulse_input_scale_coeff)) / 48'sd100;
      end
      SRC_AUX_A: begin
        src_v = 48'(aux_monitor_a);
      end
      default: begin
        src_v = 48'(aux_monitor_b);
      end
    endcase
    sel_v = src_v;
    if (q.sign_handling_select == SIGN_ABS && src_v < 0) begin
      sel_v = -src_v;
    end
    if (q.test_mode_enable == TMODE_ON) begin
      // test level is in 0.1 %, data in 0.01 %
      sel_v = 48'(q.test_level) * 48'sd10;
      if (q.sign_handling_select == SIGN_ABS && sel_v < 0) begin
        sel_v = '0;
      end
    end
    // same shaping for both waveforms
    gained = sel_v * 48'(q.gain_setting) / 48'sd1000;
    if (q.gain_basis_select == BASIS_FULL) begin
      // span from bias to full scale
      target = 48'(q.bias_setting) * 48'sd10 + gained *
        (48'(FS) - 48'(q.bias_setting) * 48'sd10) / 48'(FS);
    end else begin
      target = gained + 48'(q.bias_setting) * 48'sd10;
    end
    target = sat(target, -LIM, LIM);
    // first order lag updated once per millisecond
    err = (target <<< FILT_FRAC) - 48'(q.filt);
    d.ms_cnt = ms_tick ? '0 : q.ms_cnt + 20'h00001;
    if (ms_tick) begin
      // signed divisor, or a falling value would wrap
      d.filt = 32'(48'(q.filt) +
        err / signed'(48'(q.output_filter_time)));
    end
    duty_w = sat(48'(q.filt) >>> FILT_FRAC, '0, 48'(FS));
    d.duty = 16'(duty_w);
    freq_w = 48'(q.duty) * 48'(q.full_scale_frequency) / 48'(FS);
    if (freq_w > 48'(FSF_MAX)) begin
      freq_w = 48'(FSF_MAX);
    end
    d.freq = 16'(freq_w);
    // phase step of a 32 bit accumulator
    inc = (64'(q.freq) << 32) / 64'(CLK_HZ);
    d.phase = q.phase + 32'(inc);
    d.pwm_cnt = (q.pwm_cnt >= PWM_LAST) ? '0 : q.pwm_cnt + 20'h00001;
    pwm_hi = (48'(q.pwm_cnt) * 48'(FS)) <
      (48'(q.duty) * 48'(PWM_CYCLES));
    if (q.waveform_select == WAVE_PWM) begin
      d.pin = pwm_hi;
    end else begin
      d.pin = q.phase[31];
    end
    // analog stage owns the pin in every other type
    d.oe = (q.terminal_output_type == OTYPE_PULSE);
    // register port
    d.rdata = '0;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_WAVE: d.waveform_select = reg_wdata[1:0];
        ADDR_FSF: d.full_scale_frequency = wusat(reg_wdata, 0, int'(FSF_MAX));
        ADDR_SRC: d.monitor_source_select = reg_wdata[1:0];
        ADDR_BASIS: d.gain_basis_select = reg_wdata[1:0];
        ADDR_TMODE: d.test_mode_enable = reg_wdata[1:0];
        ADDR_FTIME: begin
          d.output_filter_time = wusat(reg_wdata, FTIME_MIN, FTIME_MAX);
        end
        ADDR_SIGN: d.sign_handling_select = reg_wdata[1:0];
        ADDR_BIAS: d.bias_setting = wsat(reg_wdata, -PCT_MAX, PCT_MAX);
        ADDR_GAIN: begin
          d.gain_setting = wsat(reg_wdata, -GAIN_MAX, GAIN_MAX);
        end
        ADDR_TLVL: d.test_level = wsat(reg_wdata, -PCT_MAX, PCT_MAX);
        ADDR_COEF: begin
          d.pulse_input_scale_coeff = wusat(reg_wdata, COEF_MIN, COEF_MAX);
        end
        ADDR_OTYPE: d.terminal_output_type = reg_wdata[1:0];
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_WAVE: d.rdata = {14'h0000, q.waveform_select};
        ADDR_FSF: d.rdata = q.full_scale_frequency;
        ADDR_SRC: d.rdata = {14'h0000, q.monitor_source_select};
        ADDR_BASIS: d.rdata = {14'h0000, q.gain_basis_select};
        ADDR_TMODE: d.rdata = {14'h0000, q.test_mode_enable};
        ADDR_FTIME: d.rdata = q.output_filter_time;
        ADDR_SIGN: d.rdata = {14'h0000, q.sign_handling_select};
        ADDR_BIAS: d.rdata = q.bias_setting;
        ADDR_GAIN: d.rdata = q.gain_setting;
        ADDR_TLVL: d.rdata = q.test_level;
        ADDR_COEF: d.rdata = q.pulse_input_scale_coeff;
        ADDR_OTYPE: d.rdata = {14'h0000, q.terminal_output_type};
        ADDR_DUTY: d.rdata = q.duty;
        ADDR_FREQ: d.rdata = q.freq;
        default: d.rdata = 16'h0000;
      endcase
    end
  end

  // ****************
  // registers
  // ****************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.waveform_select <= WAVE_FREQ;
      q.full_scale_frequency <= FSF_RST;
      q.monitor_source_select <= SRC_OUT_FREQ;
      q.gain_basis_select <= BASIS_BIAS;
      q.test_mode_enable <= TMODE_OFF;
      q.output_filter_time <= FTIME_RST;
      q.sign_handling_select <= SIGN_ABS;
      q.bias_setting <= BIAS_RST;
      q.gain_setting <= GAIN_RST;
      q.test_level <= TLVL_RST;
      q.pulse_input_scale_coeff <= COEF_RST;
      q.terminal_output_type <= OTYPE_VOLT;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign multipurpose_output_pin = q.pin;
  assign multipurpose_output_pin_oe = q.oe;

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  chk_pin_release: assert property (
    q.terminal_output_type != OTYPE_PULSE |=> !multipurpose_output_pin_oe)
    else $error("pin driven outside pulse type");
  chk_pin_drive: assert property (
    q.terminal_output_type == OTYPE_PULSE |=> multipurpose_output_pin_oe)
    else $error("pin not driven in pulse type");
  chk_freq_ceiling: assert property (
    q.freq <= FSF_MAX)
    else $error("frequency above ceiling");
  chk_duty_range: assert property (
    q.duty <= 16'(FS))
    else $error("duty above full scale");
  chk_pwm_full: assert property (
    (q.waveform_select == WAVE_PWM && q.duty == 16'(FS))
      |=> multipurpose_output_pin)
    else $error("full duty pwm not high");
  chk_pwm_zero: assert property (
    (q.waveform_select == WAVE_PWM && q.duty == 16'h0000)
      |=> !multipurpose_output_pin)
    else $error("zero duty pwm not low");
  chk_pwm_wrap: assert property (
    q.pwm_cnt == PWM_LAST |=> q.pwm_cnt == 20'h00000)
    else $error("pwm period wrong");
  chk_filt_hold: assert property (
    !ms_tick |=> $stable(q.filt))
    else $error("filter moved between ticks");
  chk_test_level: assert property (
    (q.test_mode_enable == TMODE_ON && q.gain_setting == 16'sh03E8 &&
     q.bias_setting == 16'sh0000 &&
     q.gain_basis_select == BASIS_BIAS && q.test_level >= 0)
      |-> target == 48'(q.test_level) * 48'sd10)
    else $error("test level not applied");
  chk_abs_data: assert property (
    (q.sign_handling_select == SIGN_ABS &&
     q.test_mode_enable == TMODE_OFF) |-> sel_v >= 0)
    else $error("negative data in absolute mode");
  // full scale frequency, filter time, test level and coefficient kept in range; full scale data at the set frequency; read data only in its read slot
  chk_fsf_range: assert property (
    q.full_scale_frequency <= FSF_MAX)
    else $error("full scale frequency above ceiling");
  chk_freq_full: assert property (
    q.duty == 16'(FS) |=> q.freq == $past(q.full_scale_frequency))
    else $error("full scale data not at set frequency");
  chk_ftime_range: assert property (
    q.output_filter_time >= 16'(FTIME_MIN) &&
    q.output_filter_time <= 16'(FTIME_MAX))
    else $error("filter time out of range");
  chk_tlvl_range: assert property (
    q.test_level >= -PCT_MAX && q.test_level <= PCT_MAX)
    else $error("test level out of range");
  chk_coef_range: assert property (
    q.pulse_input_scale_coeff >= 16'(COEF_MIN) &&
    q.pulse_input_scale_coeff <= 16'(COEF_MAX))
    else $error("scale coefficient out of range");
  chk_read_once: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");

  cov_pwm_pulse: cover property (
    q.waveform_select == WAVE_PWM && multipurpose_output_pin_oe &&
    $rose(multipurpose_output_pin));
  cov_freq_edge: cover property (
    q.waveform_select == WAVE_FREQ && multipurpose_output_pin_oe &&
    $rose(multipurpose_output_pin));
  cov_test_mode: cover property (
    q.test_mode_enable == TMODE_ON && ms_tick);
  cov_freq_top: cover property (q.freq == FSF_MAX);
endmodule

// ==== sim/mpo_meter.sv ====
// far-side meter and frequency counter on the multipurpose output pin
// assumes pin and enable are sampled on the block clock
`timescale 1ns/1ps
module mpo_meter (
  input wire logic clk,
  input wire logic clr,
  input wire logic pin,
  input wire logic oe,
  output int high_cnt,
  output int rise_cnt
);
  // ****************
  // counting
  // ****************
  logic last;
  // a released pin reads as nothing, never as its last level
  always @(posedge clk) begin
    if (clr) begin
      high_cnt <= 0;
      rise_cnt <= 0;
    end else if (oe) begin
      high_cnt <= high_cnt + int'(pin);
      if (pin && !last) begin
        rise_cnt <= rise_cnt + 1;
      end
    end
    last <= oe && pin;
  end
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the monitor pulse output block
// assumes shortened counts: 10 cycles per ms tick, 64-cycle pwm period
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module testbench;
  import mpo_pkg::*;
  // ****************
  // signals
  // ****************
  typedef struct packed {
    logic [15:0] src, sign, basis, bias, gain, mon, exp;
  } mpo_row_t;
  logic clk, rstn, reg_wr, reg_rd, pin, oe, clr;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic signed [15:0] ofm, pim, aux_a, aux_b;
  int high_cnt, rise_cnt, n_fail, checked;
  mpo_row_t rows [11] = '{
    '{16'h0, 16'h0, 16'h0, 16'h0, 16'h03E8, 16'h1388, 16'h1388},
    '{16'h0, 16'h0, 16'h0, 16'h0, 16'h03E8, 16'hEC78, 16'h1388},
    '{16'h0, 16'h1, 16'h0, 16'h0, 16'h03E8, 16'hEC78, 16'h0000},
    '{16'h0, 16'h0, 16'h0, 16'h0, 16'h07D0, 16'h1388, 16'h2710},
    '{16'h0, 16'h0, 16'h0, 16'h0, 16'hFC18, 16'h1388, 16'h0000},
    '{16'h0, 16'h0, 16'h0, 16'h0, 16'h01F4, 16'h1388, 16'h09C4},
    '{16'h0, 16'h0, 16'h0, 16'h00C8, 16'h03E8, 16'h1388, 16'h1B58},
    '{16'h0, 16'h0, 16'h1, 16'h00C8, 16'h03E8, 16'h1388, 16'h1770},
    '{16'h0, 16'h0, 16'h1, 16'h00C8, 16'h03E8, 16'h0000, 16'h07D0},
    '{16'h2, 16'h0, 16'h0, 16'h0, 16'h03E8, 16'h0000, 16'h0FA0},
    '{16'h3, 16'h0, 16'h0, 16'h0, 16'h03E8, 16'h0000, 16'h1770}};
  logic [19:0] rst_tab [13] = '{20'h00001, 20'h105A0, 20'h20000, 20'h30000,
    20'h40000, 20'h5000A, 20'h60000, 20'h70000, 20'h803E8, 20'h903E8,
    20'hA0064, 20'hB0001, 20'hE0000};

  mpo_core #(.MS_CYCLES(10), .PWM_CYCLES(64)) dut (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .output_frequency_monitor(ofm), .pulse_input_monitor(pim),
    .aux_monitor_a(aux_a), .aux_monitor_b(aux_b),
    .multipurpose_output_pin(pin), .multipurpose_output_pin_oe(oe));
  mpo_meter meter (.clk(clk), .clr(clr), .pin(pin), .oe(oe),
    .high_cnt(high_cnt), .rise_cnt(rise_cnt));

  // ****************
  // tasks
  // ****************
  // one idle cycle between accesses keeps each strobe a single pulse
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic look(input logic [3:0] a);
    repeat (40) @(posedge clk);
    rd(a, v);
  endtask
  task automatic measure(input int n);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************
  // stimulus
  // ****************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    results;
  end
  initial begin
    {rstn, reg_wr, reg_rd, clr, reg_addr, reg_wdata} = '0;
    {n_fail, checked} = '0;
    ofm = 16'sh0000;
    pim = 16'sh0BB8;
    aux_a = 16'sh0FA0;
    aux_b = 16'sh1770;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    wr(ADDR_OTYPE, 16'h0003);
    repeat (2) @(posedge clk);
    #1;
    `CHK("oe", 1'b1, oe)
    wr(ADDR_FTIME, 16'h0001);
    wr(ADDR_WAVE, 16'h0000);
    for (int i = 0; i < 11; i++) begin
      wr(ADDR_SRC, rows[i].src);
      wr(ADDR_SIGN, rows[i].sign);
      wr(ADDR_BASIS, rows[i].basis);
      wr(ADDR_BIAS, rows[i].bias);
      wr(ADDR_GAIN, rows[i].gain);
      ofm <= rows[i].mon;
      look(ADDR_DUTY);
      `CHK("duty", rows[i].exp, v)
    end
    // test level replaces the monitor, still through gain
    wr(ADDR_SRC, 16'h0000);
    wr(ADDR_BIAS, 16'h0000);
    wr(ADDR_BASIS, 16'h0000);
    wr(ADDR_TMODE, 16'h0001);
    wr(ADDR_TLVL, 16'h01F4);
    look(ADDR_DUTY);
    `CHK("tduty", 16'h1388, v)
    measure(64);
    `CHK("high", 32, high_cnt)
    wr(ADDR_SIGN, 16'h0001);
    wr(ADDR_GAIN, 16'hFC18);
    wr(ADDR_TLVL, 16'hFE0C);
    look(ADDR_DUTY);
    `CHK("tneg", 16'h1388, v)
    wr(ADDR_GAIN, 16'h03E8);
    ofm <= 16'sh0BB8;
    wr(ADDR_TMODE, 16'h0000);
    look(ADDR_DUTY);
    `CHK("tback", 16'h0BB8, v)
    wr(ADDR_SRC, 16'h0001);
    wr(ADDR_COEF, 16'h00C8);
    look(ADDR_DUTY);
    `CHK("coef", 16'h1770, v)
    pim <= 16'shF448;
    look(ADDR_DUTY);
    `CHK("ncoef", 16'h0000, v)
    wr(ADDR_SRC, 16'h0000);
    wr(ADDR_WAVE, 16'h0001);
    ofm <= 16'sh2710;
    look(ADDR_FREQ);
    `CHK("freq", 16'h05A0, v)
    wr(ADDR_BIAS, 16'h00C8);
    ofm <= 16'sh1388;
    look(ADDR_FREQ);
    `CHK("fbias", 16'h03F0, v)
    wr(ADDR_BIAS, 16'h0000);
    wr(ADDR_FSF, 16'hFFFF);
    wr(ADDR_GAIN, 16'h07D0);
    ofm <= 16'sh2710;
    look(ADDR_FREQ);
    `CHK("fcap", 16'h7D00, v)
    // 32 kHz over 31250 cycles gives ten edges, phase allows one more or less
    measure(31250);
    `CHK("edges", 1'b1, rise_cnt >= 9 && rise_cnt <= 11)
    wr(ADDR_OTYPE, 16'h0001);
    measure(8000);
    `CHK("voe", 1'b0, oe)
    `CHK("vrise", 0, rise_cnt)
    // filter from a settled zero, slow enough to stay partway after 27 cycles
    wr(ADDR_GAIN, 16'h03E8);
    wr(ADDR_FTIME, 16'h0001);
    ofm <= 16'sh0000;
    look(ADDR_DUTY);
    wr(ADDR_FTIME, 16'h000A);
    ofm <= 16'sh2710;
    repeat (25) @(posedge clk);
    rd(ADDR_DUTY, v);
    `CHK("filt", 1'b1, v >= 16'h03E8 && v <= 16'h0A96)
    @(posedge clk);
    #1;
    `CHK("rdone", 16'h0000, reg_rdata)
    // and back down from a settled full scale, a negative step
    wr(ADDR_FTIME, 16'h0001);
    look(ADDR_DUTY);
    wr(ADDR_FTIME, 16'h000A);
    ofm <= 16'sh0000;
    repeat (25) @(posedge clk);
    rd(ADDR_DUTY, v);
    `CHK("fdown", 1'b1, v >= 16'h1C7A && v <= 16'h2328)
    // reset in mid-run restores every default
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("roe", 1'b0, oe)
    @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      rd(rst_tab[i][19:16], v);
      `CHK("reset", rst_tab[i][15:0], v)
    end
    results;
  end
endmodule
